/* core/upi_irq_logic.sv */
// Behaviour
// - Seven separately masked conditions form interrupt status for the interrupt pipe.
// - A host read of interrupt status clears all pending interrupts.
// - With interrupt enable set, each rising nAck edge raises acknowledge interrupt.
// - Pending acknowledge interrupt shows in extended control flag.
// - EPP time-out interrupt enabled by its own mask bit at 0.
// - EPP time-out declared when peripheral misses handshake within limit.
// - Fault interrupt enabled by mask at 0; flag in extended control.
// - In ECP mode, nFault falling or low while unmasked raises fault.
// - Bulk-in enabled by mask at 0; interrupt and empty flags shown.
// - Bulk-in interrupt raised while inbound data is available.
// - Bulk-out enabled by mask at 0; empty flag shown.
// - Bulk-out interrupt raised when outbound pipeline becomes empty.
// - Line-change enabled by mask at 0; no status flag.
// - Any change on peripheral-driven lines raises line-change interrupt.
// - Disconnect enabled by mask at 0; no status flag.
// - PLH falling raises disconnect interrupt.
// - PLH low with all five lines high over one second raises disconnect.
// - Filter-bypass strap low passes inputs without digital filtering.
// - High-drive strap low drives all outputs push-pull continuously.
// - Power strap high reports self-powered in Get-Status reply.
// - Software override selects filter enable bit, else strap decides.
// - ECP mode is mode field value 011.
// - Mask bits: disconnect 7, change 6, bulk-in 5, bulk-out 4, fault 3.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module upi_irq_logic #(
	parameter int IDLE_CYCLES = upi_pkg::IDLE_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrStb,
	input  wire logic       regRdStb,
	output logic      [7:0] regRdData,
	input  wire logic       ackLineIn,
	input  wire logic       busyLineIn,
	input  wire logic       faultLineIn,
	input  wire logic       perrLineIn,
	input  wire logic       selectLineIn,
	input  wire logic       plhLineIn,
	input  wire logic       filterStrapIn,
	input  wire logic       drive_strap_pin,
	input  wire logic       powerStrapIn,
	input  wire logic       eppBusy,
	input  wire logic       eppStrobe,
	input  wire logic       eppReply,
	input  wire logic       bulkInAvail,
	input  wire logic       bulkOutEmpty,
	input  wire logic       irqPipeRead,
	output logic      [6:0] irqPipeData,
	output logic            irqPipeValid,
	output logic      [5:0] filtLines,
	output logic            highDrive,
	output logic            selfPowered
);
	logic [5:0]  syncA_ff;
	logic [5:0]  syncB_ff;
	logic [2:0]  strapA_ff;
	logic [2:0]  strapB_ff;
	logic [2:0]  strap_ff;
	logic        strapDone_ff;
	logic [5:0]  lines_ff;
	logic [5:0]  linesPrev_ff;
	logic [1:0]  filtCnt_ff [6];
	logic [5:0]  filtVal_ff;
	logic [7:0]  control_ff;
	logic [7:0]  bridge_ff;
	logic [7:0]  setup_ff;
	logic [2:0]  mode_ff;
	logic [6:0]  pend_ff;
	logic [6:0]  nxt_pend;
	logic [31:0] idleCnt_ff;
	logic        idleFired_ff;
	logic [15:0] eppCnt_ff;
	logic        bulkOutPrev_ff;
	logic [7:0]  regRdData_ff;
	logic        filterOn;
	logic [5:0]  lineSel;
	logic        isEcp;
	logic [6:0]  event_now;
	logic [6:0]  enable;
	logic        statRead;
	logic        idleHit;
	logic        eppHit;
	logic [7:0]  extCtrl;

	// Pin inputs pass two flip-flops before any logic.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA_ff <= 6'h3f;
			syncB_ff <= 6'h3f;
		end else begin
			syncA_ff <= {plhLineIn, selectLineIn, perrLineIn,
				faultLineIn, busyLineIn, ackLineIn};
			syncB_ff <= syncA_ff;
		end
	end

	// Strap pins pass two flip-flops that keep running through reset.
	always_ff @(posedge core_clk) begin
		strapA_ff <= {powerStrapIn, drive_strap_pin, filterStrapIn};
		strapB_ff <= strapA_ff;
	end

	// The level sampled during reset is held from the first edge after it.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_ff     <= 3'h7;
			strapDone_ff <= 1'b0;
		end else if (!strapDone_ff) begin
			strap_ff     <= strapB_ff;
			strapDone_ff <= 1'b1;
		end
	end

	// Filter on unless bypassed.
	assign filterOn = setup_ff[upi_pkg::SET_FILT_OVR] ?
		setup_ff[upi_pkg::SET_FILT_EN] : strap_ff[0];

	// Each line is accepted after staying stable for a few cycles.
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_filt
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					filtCnt_ff[gi] <= 2'h0;
					filtVal_ff[gi] <= 1'b1;
				end else if (syncB_ff[gi] == filtVal_ff[gi]) begin
					filtCnt_ff[gi] <= 2'h0;
				end else if (filtCnt_ff[gi] ==
					2'(upi_pkg::FILT_CYCLES - 1)) begin
					filtCnt_ff[gi] <= 2'h0;
					filtVal_ff[gi] <= syncB_ff[gi];
				end else begin
					filtCnt_ff[gi] <= filtCnt_ff[gi] + 2'h1;
				end
			end
		end
	endgenerate

	assign lineSel = filterOn ? filtVal_ff : syncB_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lines_ff     <= 6'h3f;
			linesPrev_ff <= 6'h3f;
		end else begin
			lines_ff     <= lineSel;
			linesPrev_ff <= lines_ff;
		end
	end

	// Idle-high timer for disconnect detection.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			idleCnt_ff   <= 32'h0;
			idleFired_ff <= 1'b0;
		end else if (lines_ff[5] || (lines_ff[4:0] != 5'h1f)) begin
			idleCnt_ff   <= 32'h0;
			idleFired_ff <= 1'b0;
		end else if (idleCnt_ff < 32'(IDLE_CYCLES)) begin
			idleCnt_ff <= idleCnt_ff + 32'h1;
		end else begin
			idleFired_ff <= 1'b1;
		end
	end
	assign idleHit = !idleFired_ff && idleCnt_ff == 32'(IDLE_CYCLES);

	// EPP handshake watchdog.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			eppCnt_ff <= 16'h0;
		end else if (!eppBusy || eppReply || eppStrobe) begin
			eppCnt_ff <= 16'h0;
		end else if (eppCnt_ff <= 16'(upi_pkg::EPP_CYCLES)) begin
			eppCnt_ff <= eppCnt_ff + 16'h1;
		end
	end
	assign eppHit = eppCnt_ff == 16'(upi_pkg::EPP_CYCLES);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bulkOutPrev_ff <= 1'b1;
		end else begin
			bulkOutPrev_ff <= bulkOutEmpty;
		end
	end

	assign isEcp = mode_ff == upi_pkg::MODE_ECP;

	always_comb begin
		event_now = 7'h0;
		event_now[upi_pkg::IRQ_ACK] = lines_ff[0] && !linesPrev_ff[0];
		event_now[upi_pkg::IRQ_EPP_TO] = eppHit;
		event_now[upi_pkg::IRQ_FAULT] = isEcp &&
			((linesPrev_ff[2] && !lines_ff[2]) || !lines_ff[2]);
		event_now[upi_pkg::IRQ_BULK_IN] = bulkInAvail;
		event_now[upi_pkg::IRQ_BULK_OUT] = bulkOutEmpty &&
			!bulkOutPrev_ff;
		event_now[upi_pkg::IRQ_CHANGE] = lines_ff != linesPrev_ff;
		event_now[upi_pkg::IRQ_DISCON] = (linesPrev_ff[5] && !lines_ff[5])
			|| idleHit;
	end

	always_comb begin
		enable = 7'h0;
		enable[upi_pkg::IRQ_ACK] = control_ff[upi_pkg::CTL_IRQ_EN_BIT];
		enable[upi_pkg::IRQ_EPP_TO] =
			!control_ff[upi_pkg::CTL_EPP_MASK_BIT];
		enable[upi_pkg::IRQ_FAULT] = !bridge_ff[upi_pkg::MSK_FAULT];
		enable[upi_pkg::IRQ_BULK_IN] = !bridge_ff[upi_pkg::MSK_BULK_IN];
		enable[upi_pkg::IRQ_BULK_OUT] =
			!bridge_ff[upi_pkg::MSK_BULK_OUT];
		enable[upi_pkg::IRQ_CHANGE] = !bridge_ff[upi_pkg::MSK_CHANGE];
		enable[upi_pkg::IRQ_DISCON] = !bridge_ff[upi_pkg::MSK_DISCON];
	end

	assign statRead = irqPipeRead ||
		(regRdStb && regAddr == upi_pkg::ADDR_IRQ_STAT);

	// Pending bits: a read clears, but a new event in that cycle wins.
	always_comb begin
		nxt_pend = statRead ? 7'h0 : pend_ff;
		nxt_pend = nxt_pend | (event_now & enable);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_ff <= 7'h0;
		end else begin
			pend_ff <= nxt_pend;
		end
	end

	// Interrupt pipe output.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqPipeData  <= 7'h0;
			irqPipeValid <= 1'b0;
		end else begin
			irqPipeData  <= nxt_pend;
			irqPipeValid <= |nxt_pend;
		end
	end

	// Software registers.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			control_ff <= upi_pkg::RST_CONTROL;
			bridge_ff  <= upi_pkg::RST_BRIDGE;
			setup_ff   <= upi_pkg::RST_SETUP;
			mode_ff    <= upi_pkg::RST_MODE;
		end else if (regWrStb) begin
			if (regAddr == upi_pkg::ADDR_CONTROL) begin
				control_ff <= regWrData;
			end else if (regAddr == upi_pkg::ADDR_BRIDGE) begin
				bridge_ff <= {regWrData[7:3], 1'b0, regWrData[1:0]};
			end else if (regAddr == upi_pkg::ADDR_SETUP) begin
				setup_ff <= {6'h0, regWrData[1:0]};
			end else if (regAddr == upi_pkg::ADDR_EXT_CTRL) begin
				mode_ff <= regWrData[7:5];
			end
		end
	end

	always_comb begin
		extCtrl = 8'h0;
		extCtrl[upi_pkg::EXT_ACK_IRQ] = pend_ff[upi_pkg::IRQ_ACK];
		extCtrl[upi_pkg::EXT_FAULT_IRQ] = pend_ff[upi_pkg::IRQ_FAULT];
		extCtrl[upi_pkg::EXT_BIN_IRQ] = pend_ff[upi_pkg::IRQ_BULK_IN];
		extCtrl[upi_pkg::EXT_BIN_EMPTY] = !bulkInAvail;
		extCtrl[upi_pkg::EXT_BOUT_EMPTY] = bulkOutEmpty;
		extCtrl[7:5] = mode_ff;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData_ff <= 8'h0;
		end else if (regRdStb) begin
			if (regAddr == upi_pkg::ADDR_CONTROL) begin
				regRdData_ff <= control_ff;
			end else if (regAddr == upi_pkg::ADDR_BRIDGE) begin
				regRdData_ff <= bridge_ff;
			end else if (regAddr == upi_pkg::ADDR_SETUP) begin
				regRdData_ff <= setup_ff;
			end else if (regAddr == upi_pkg::ADDR_EXT_CTRL) begin
				regRdData_ff <= extCtrl;
			end else if (regAddr == upi_pkg::ADDR_IRQ_STAT) begin
				regRdData_ff <= {1'b0, pend_ff};
			end else begin
				regRdData_ff <= 8'h0;
			end
		end else begin
			regRdData_ff <= 8'h0;
		end
	end
	assign regRdData = regRdData_ff;

	// Board mode outputs.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			filtLines   <= 6'h3f;
			highDrive   <= 1'b0;
			selfPowered <= 1'b0;
		end else begin
			filtLines   <= lineSel;
			highDrive   <= strapDone_ff && !strap_ff[1];
			selfPowered <= strapDone_ff && strap_ff[2];
		end
	end
endmodule // upi_irq_logic

/* core/upi_pkg.sv */
package upi_pkg;
	// Interrupt status bit positions.
	localparam int IRQ_ACK      = 0;
	localparam int IRQ_EPP_TO   = 1;
	localparam int IRQ_FAULT    = 2;
	localparam int IRQ_BULK_IN  = 3;
	localparam int IRQ_BULK_OUT = 4;
	localparam int IRQ_CHANGE   = 5;
	localparam int IRQ_DISCON   = 6;
	localparam int IRQ_COUNT    = 7;

	// Register offsets on the plain register port.
	localparam logic [3:0] ADDR_CONTROL  = 4'h2;
	localparam logic [3:0] ADDR_EXT_CTRL = 4'h5;
	localparam logic [3:0] ADDR_BRIDGE   = 4'h7;
	localparam logic [3:0] ADDR_SETUP    = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h9;

	// Control register fields.
	localparam int CTL_IRQ_EN_BIT   = 4;
	localparam int CTL_EPP_MASK_BIT = 0;

	// Bridge control register mask bits.
	localparam int MSK_DISCON   = 7;
	localparam int MSK_CHANGE   = 6;
	localparam int MSK_BULK_IN  = 5;
	localparam int MSK_BULK_OUT = 4;
	localparam int MSK_FAULT    = 3;

	// Extended control register flag positions.
	localparam int EXT_ACK_IRQ    = 0;
	localparam int EXT_FAULT_IRQ  = 1;
	localparam int EXT_BIN_IRQ    = 2;
	localparam int EXT_BIN_EMPTY  = 3;
	localparam int EXT_BOUT_EMPTY = 4;
	localparam int EXT_MODE_LSB   = 5;

	// Setup register fields.
	localparam int SET_FILT_EN  = 0;
	localparam int SET_FILT_OVR = 1;

	// Reset values and the ECP mode code.
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_BRIDGE  = 8'hf8;
	localparam logic [7:0] RST_SETUP   = 8'h01;
	localparam logic [2:0] RST_MODE    = 3'h0;
	localparam logic [2:0] MODE_ECP    = 3'h3;

	// Timing.
	localparam int CLK_MHZ         = 250;
	localparam int IDLE_TIME_MS    = 1000;
	localparam int IDLE_CYCLES     = IDLE_TIME_MS * 1000 * CLK_MHZ;
	localparam int EPP_TIMEOUT_US  = 10;
	localparam int EPP_CYCLES      = EPP_TIMEOUT_US * CLK_MHZ;
	localparam int FILT_CYCLES     = 3;
endpackage

/* verif/upi_irq_logic_props.sv */
`timescale 1ns/1ps
module upi_irq_logic_props (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       regRdStb,
	input wire logic [7:0] regRdData,
	input wire logic       ackLineIn,
	input wire logic       plhLineIn,
	input wire logic       eppBusy,
	input wire logic       bulkInAvail,
	input wire logic       bulkOutEmpty,
	input wire logic       irqPipeRead,
	input wire logic [6:0] irqPipeData,
	input wire logic       irqPipeValid,
	input wire logic       highDrive,
	input wire logic       selfPowered
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [3:0] upCnt_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			upCnt_ff <= 4'h0;
		else if (upCnt_ff != 4'hf)
			upCnt_ff <= upCnt_ff + 4'h1;
	end
	property p_rd_idle; !$past(regRdStb) |-> regRdData == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
	property p_straps;
		upCnt_ff == 4'hf |-> $stable(highDrive) && $stable(selfPowered);
	endproperty
	a_straps: assert property (p_straps) else $error("strap level moved");
	property p_valid; irqPipeValid == (irqPipeData != 7'h00); endproperty
	a_valid: assert property (p_valid) else $error("valid flag wrong");
	property p_hold;
		irqPipeValid && !irqPipeRead && !regRdStb |=> irqPipeValid;
	endproperty
	a_hold: assert property (p_hold) else $error("pending lost");
	property p_ack; $rose(irqPipeData[0]) |-> ackLineIn; endproperty
	a_ack: assert property (p_ack) else $error("ack without rise");
	property p_discon; $rose(irqPipeData[6]) |-> !plhLineIn; endproperty
	a_discon: assert property (p_discon) else $error("bad disconnect");
	property p_bin; $rose(irqPipeData[3]) |-> $past(bulkInAvail); endproperty
	a_bin: assert property (p_bin) else $error("bulk in without data");
	property p_bout; $rose(irqPipeData[4]) |-> $past(bulkOutEmpty); endproperty
	a_bout: assert property (p_bout) else $error("bulk out not empty");
	property p_epp; $rose(irqPipeData[1]) |-> $past(eppBusy, 2); endproperty
	a_epp: assert property (p_epp) else $error("timeout while idle");
endmodule // upi_irq_logic_props
bind upi_irq_logic upi_irq_logic_props chk_u (
	.core_clk     (core_clk),
	.rst_b        (rst_b),
	.regRdStb     (regRdStb),
	.regRdData    (regRdData),
	.ackLineIn    (ackLineIn),
	.plhLineIn    (plhLineIn),
	.eppBusy      (eppBusy),
	.bulkInAvail  (bulkInAvail),
	.bulkOutEmpty (bulkOutEmpty),
	.irqPipeRead  (irqPipeRead),
	.irqPipeData  (irqPipeData),
	.irqPipeValid (irqPipeValid),
	.highDrive    (highDrive),
	.selfPowered  (selfPowered)
);

/* verif/upi_irq_logic_test.sv */
`timescale 1ns/1ps
module upi_irq_logic_test;
	logic       core_clk, rst_b, regWrStb, regRdStb, irqPipeRead;
	logic [3:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic [5:0] lineSet, filtLines;
	logic [6:0] irqPipeData;
	logic       ackLineIn, busyLineIn, faultLineIn, perrLineIn;
	logic       selectLineIn, plhLineIn, eppReply, answerEpp, eppBusy;
	logic       filterStrapIn, drive_strap_pin, powerStrapIn, eppStrobe;
	logic       bulkInAvail, bulkOutEmpty, irqPipeValid, highDrive;
	logic       selfPowered;
	int         miscompares, tests_run;
	upi_irq_logic #(.IDLE_CYCLES(50)) dut_u (.*);
	upi_periph_model per_u (.*);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic end_sim();
		$display("checks %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		#1 chk("regRdData", regRdData, e);
		@(posedge core_clk);
	endtask
	task automatic waitb(int b, int lim);
		int i;
		for (i = 0; i < lim && irqPipeData[b] !== 1'b1; i++)
			@(posedge core_clk);
		chk("irqPipeData bit", irqPipeData[b], 1'b1);
		if (i == lim)
			end_sim();
	endtask
	task automatic quiet(int n);
		repeat (n) @(posedge core_clk);
		chk("irqPipeData", irqPipeData, 7'h00);
	endtask
	task automatic clr();
		irqPipeRead <= 1'b1;
		@(posedge core_clk);
		irqPipeRead <= 1'b0;
		quiet(1);
	endtask
	initial begin
		miscompares = 0;
		tests_run = 0;
		rst_b = 1'b0;
		{regWrStb, regRdStb, irqPipeRead, eppBusy, eppStrobe} = '0;
		{bulkInAvail, bulkOutEmpty, answerEpp, drive_strap_pin} = '0;
		{filterStrapIn, powerStrapIn} = 2'h3;
		{regAddr, regWrData} = '0;
		lineSet = 6'h3f;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (10) @(posedge core_clk);
		drive_strap_pin <= 1'b1;
		powerStrapIn <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("highDrive", highDrive, 1'b1);
		chk("selfPowered", selfPowered, 1'b1);
		rd(upi_pkg::ADDR_CONTROL, upi_pkg::RST_CONTROL);
		rd(upi_pkg::ADDR_BRIDGE, upi_pkg::RST_BRIDGE);
		rd(upi_pkg::ADDR_SETUP, upi_pkg::RST_SETUP);
		rd(4'hf, 8'h00);
		chk("filtLines", filtLines, 6'h3f);
		wr(upi_pkg::ADDR_BRIDGE, 8'hb8);
		for (int k = 0; k < 6; k++) begin
			lineSet[k] <= 1'b0;
			waitb(upi_pkg::IRQ_CHANGE, 20);
			clr();
		end
		chk("filtLines", filtLines, 6'h00);
		lineSet[4] <= 1'b1;
		@(posedge core_clk);
		lineSet[4] <= 1'b0;
		quiet(20);
		wr(upi_pkg::ADDR_SETUP, 8'h02);
		rd(upi_pkg::ADDR_SETUP, 8'h02);
		lineSet[4] <= 1'b1;
		@(posedge core_clk);
		lineSet[4] <= 1'b0;
		waitb(upi_pkg::IRQ_CHANGE, 20);
		repeat (4) @(posedge core_clk);
		clr();
		wr(upi_pkg::ADDR_SETUP, upi_pkg::RST_SETUP);
		wr(upi_pkg::ADDR_BRIDGE, upi_pkg::RST_BRIDGE);
		lineSet <= 6'h3f;
		quiet(20);
		wr(upi_pkg::ADDR_CONTROL, 8'h10);
		lineSet[0] <= 1'b0;
		quiet(15);
		lineSet[0] <= 1'b1;
		waitb(upi_pkg::IRQ_ACK, 20);
		rd(upi_pkg::ADDR_EXT_CTRL, 8'h09);
		clr();
		rd(upi_pkg::ADDR_EXT_CTRL, 8'h08);
		wr(upi_pkg::ADDR_EXT_CTRL, 8'h60);
		wr(upi_pkg::ADDR_BRIDGE, 8'hf0);
		lineSet[2] <= 1'b0;
		waitb(upi_pkg::IRQ_FAULT, 20);
		rd(upi_pkg::ADDR_EXT_CTRL, 8'h6a);
		lineSet[2] <= 1'b1;
		repeat (12) @(posedge core_clk);
		clr();
		wr(upi_pkg::ADDR_BRIDGE, 8'hd8);
		bulkInAvail <= 1'b1;
		waitb(upi_pkg::IRQ_BULK_IN, 20);
		rd(upi_pkg::ADDR_EXT_CTRL, 8'h64);
		bulkInAvail <= 1'b0;
		repeat (4) @(posedge core_clk);
		clr();
		wr(upi_pkg::ADDR_BRIDGE, 8'he8);
		bulkOutEmpty <= 1'b1;
		waitb(upi_pkg::IRQ_BULK_OUT, 20);
		rd(upi_pkg::ADDR_EXT_CTRL, 8'h78);
		clr();
		wr(upi_pkg::ADDR_BRIDGE, 8'h78);
		lineSet[5] <= 1'b0;
		waitb(upi_pkg::IRQ_DISCON, 20);
		clr();
		quiet(20);
		waitb(upi_pkg::IRQ_DISCON, 100);
		clr();
		lineSet[1] <= 1'b0;
		repeat (10) @(posedge core_clk);
		lineSet[1] <= 1'b1;
		quiet(30);
		waitb(upi_pkg::IRQ_DISCON, 100);
		clr();
		lineSet[5] <= 1'b1;
		wr(upi_pkg::ADDR_BRIDGE, upi_pkg::RST_BRIDGE);
		eppBusy <= 1'b1;
		waitb(upi_pkg::IRQ_EPP_TO, 3000);
		eppBusy <= 1'b0;
		clr();
		answerEpp <= 1'b1;
		eppBusy <= 1'b1;
		quiet(2800);
		answerEpp <= 1'b0;
		wr(upi_pkg::ADDR_CONTROL, 8'h11);
		quiet(2800);
		end_sim();
	end
endmodule // upi_irq_logic_test

/* verif/upi_periph_model.sv */
`timescale 1ns/1ps
module upi_periph_model (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic [5:0] lineSet,
	input  wire logic       answerEpp,
	input  wire logic       eppBusy,
	output logic            ackLineIn,
	output logic            busyLineIn,
	output logic            faultLineIn,
	output logic            perrLineIn,
	output logic            selectLineIn,
	output logic            plhLineIn,
	output logic            eppReply
);
	// Peripheral lines follow the commanded levels one edge later.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			{plhLineIn, selectLineIn, perrLineIn} <= 3'h7;
		else
			{plhLineIn, selectLineIn, perrLineIn} <= lineSet[5:3];
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			{faultLineIn, busyLineIn, ackLineIn} <= 3'h7;
		else
			{faultLineIn, busyLineIn, ackLineIn} <= lineSet[2:0];
	end
	// A handshake is answered only when the peripheral is told to.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			eppReply <= 1'b0;
		else
			eppReply <= eppBusy & answerEpp & !eppReply;
	end
endmodule // upi_periph_model
